// File: design/rsm_params.svh
// register offsets, field positions, reset values and timing counts
// assumes: included by the package and the design module by bare name
`ifndef RSM_PARAMS_SVH
`define RSM_PARAMS_SVH

// ****************************************************************
// register offsets (byte addresses on the plain register port)
// ****************************************************************
`define RSM_OFS_SLOT_INTERVAL   8'h25
`define RSM_OFS_AUX_SELECT      8'h26
`define RSM_OFS_PRESET_27       8'h27
`define RSM_OFS_FIFO_WARN       8'h29
`define RSM_OFS_COUNTDOWN_CFG   8'h2A
`define RSM_OFS_IRQ_STATUS      8'h40
`define RSM_OFS_IRQ_MASK        8'h41
`define RSM_OFS_RELOAD          8'h42
`define RSM_OFS_CONTROL         8'h43
`define RSM_OFS_COUNT_VALUE     8'h44

// ****************************************************************
// reset values
// ****************************************************************
`define RSM_RST_SLOT_INTERVAL   8'h00
`define RSM_RST_AUX_SELECT      8'h00
`define RSM_RST_FIFO_WARN       8'h08
`define RSM_RST_COUNTDOWN_CFG   8'h07
`define RSM_RST_RELOAD          8'h0A
`define RSM_RST_IRQ_MASK        8'h00

// ****************************************************************
// field positions
// ****************************************************************
`define RSM_AUX_SEL_LSB         0
`define RSM_AUX_SEL_MSB         2
`define RSM_AUX_SLOT_TOP_BIT    4
`define RSM_WARN_LSB            0
`define RSM_WARN_MSB            5
`define RSM_CFG_EXP_LSB         0
`define RSM_CFG_EXP_MSB         4
`define RSM_CFG_AUTO_BIT        5
`define RSM_IRQ_EXPIRED_BIT     0
`define RSM_IRQ_SLOT_BIT        1
`define RSM_CTRL_START_BIT      0
`define RSM_CTRL_STOP_BIT       1

// ****************************************************************
// timing: carrier rate made from the system clock by an accumulator
// ****************************************************************
`define RSM_CLOCK_KHZ           100000
`define RSM_CARRIER_KHZ         13560
`define RSM_EXP_MAX             5'd21
`define RSM_FIFO_DEPTH          7'd64
`define RSM_SLOT_UNIT_CARRIER   128

`endif

// File: design/rsm_pkg.sv
// types shared by the slot, aux-output, fifo-flag and countdown logic
// assumes: rsm_params.svh on the include path
`include "rsm_params.svh"

package rsm_pkg;

  // slot interval sequencer
  typedef enum logic [1:0]
  {
    RSM_SLOT_IDLE = 2'b00,  // no frame pending
    RSM_SLOT_WAIT = 2'b01   // counting toward the next automatic frame
  } rsm_slot_e;

  // frame events from the transmitter, same clock domain
  typedef struct packed
  {
    logic tx_begin;    // first bit of a command frame leaves
    logic tx_end;      // command frame transmission complete
    logic quit_frame;  // next automatic frame is a quit frame
  } rsm_frame_s;

  // candidate sources for the auxiliary pin, same clock domain
  typedef struct packed
  {
    logic miller_env;     // modulation envelope, miller coded
    logic serial_data;    // serial stream before miller coding
    logic carrier_demod;  // energy carrier demodulator output
    logic subcarr_demod;  // subcarrier demodulator, manchester coded
    logic type_a_106;     // link is type a at 106 kbd
  } rsm_aux_src_s;

  // plain register port request
  typedef struct packed
  {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } rsm_bus_s;

  // all state of the block
  typedef struct packed
  {
    logic [7:0] slot_interval;
    logic       slot_interval_top_bit;
    logic [2:0] aux_output_source;
    logic [7:0] preset_slot_twenty_seven;
    logic [5:0] fifo_warn_threshold;
    logic       countdown_auto_reload;
    logic [4:0] countdown_divider_exponent;
    logic [7:0] countdown_reload_value;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic [7:0] rd_data;
    logic       aux_output_pin;
    logic       fifo_nearly_full_flag;
    logic       fifo_nearly_empty_flag;
    logic [16:0] carrier_acc;
    logic [20:0] prescale_cnt;
    logic [7:0] count_value;
    logic       count_run;
    rsm_slot_e  slot_state;
    logic [8:0] slot_cnt;
    logic [6:0] slot_unit_cnt;
    logic       slot_from_begin;
    logic       auto_send;
  } rsm_state_s;

endpackage

// File: design/rsm_cfg.sv
// configuration bank of the reader: slot interval, aux pin source,
// fifo warning level and countdown clock with its countdown engine
// assumes: single 100 MHz clock, synchronous active-high reset, all
// event and source inputs come from logic on the same clock
//
// How it works
// - slot interval spaces automatically sent frames
// - slot timing starts at command transmission end
// - quit frame timing references command frame start
// - aux bit 4 is slot interval top bit
// - selector 000 low, 001 high, 11x reserved
// - 010 miller envelope, 011 pre-miller serial data
// - 100/101 demodulator outputs, type a 106 only
// - nearly full when free space at or below threshold
// - nearly empty when entries at or below threshold
// - auto reload restarts countdown at expiry
// - otherwise stop at zero, set expired flag
// - tick is carrier divided by two to exponent, exponent clamped at 21
// - start loads reload value; zero never starts
`include "rsm_params.svh"
`timescale 1ns/1ps
`default_nettype none

module rsm_cfg
(
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire rsm_pkg::rsm_bus_s     bus,
  output logic [7:0]                 rd_data,
  input  wire rsm_pkg::rsm_frame_s   frame,
  input  wire rsm_pkg::rsm_aux_src_s aux_src,
  input  wire logic [6:0]            fifo_count,
  input  wire logic                  count_start,
  input  wire logic                  count_stop,
  output logic                       aux_output_pin,
  output logic                       fifo_nearly_full_flag,
  output logic                       fifo_nearly_empty_flag,
  output logic                       countdown_expired_flag,
  output logic                       auto_send,
  output logic [7:0]                 preset_value,
  output logic                       irq
);

  // ****************************************************************
  // state and reset image
  // ****************************************************************
  rsm_pkg::rsm_state_s s;       // registered state
  rsm_pkg::rsm_state_s next_s;  // next state

  // reset image; preset field is ignored on reset
  localparam rsm_pkg::rsm_state_s RST_S = '{
    slot_interval:              `RSM_RST_SLOT_INTERVAL,
    slot_interval_top_bit:      1'b0,
    aux_output_source:          3'h0,
    preset_slot_twenty_seven:   8'h00,
    fifo_warn_threshold:        6'h08,
    countdown_auto_reload:      1'b0,
    countdown_divider_exponent: 5'h07,
    countdown_reload_value:     `RSM_RST_RELOAD,
    irq_status:                 2'h0,
    irq_mask:                   2'h0,
    rd_data:                    8'h00,
    aux_output_pin:             1'b0,
    fifo_nearly_full_flag:      1'b0,
    fifo_nearly_empty_flag:     1'b0,
    carrier_acc:                17'h0_0000,
    prescale_cnt:               21'h00_0000,
    count_value:                8'h00,
    count_run:                  1'b0,
    slot_state:                 rsm_pkg::RSM_SLOT_IDLE,
    slot_cnt:                   9'h000,
    slot_unit_cnt:              7'h00,
    slot_from_begin:            1'b0,
    auto_send:                  1'b0
  };

  // ****************************************************************
  // derived constants
  // ****************************************************************
  localparam logic [16:0] CLK_K = 17'(`RSM_CLOCK_KHZ);
  localparam logic [16:0] CAR_K = 17'(`RSM_CARRIER_KHZ);
  localparam logic [6:0]  SLOT_UNIT_LAST =
    7'(`RSM_SLOT_UNIT_CARRIER - 1);

  // ****************************************************************
  // combinational helpers
  // ****************************************************************
  logic [17:0] acc_sum;       // accumulator sum, one bit wider
  logic        carrier_tick;  // one pulse per 13.56 MHz period
  logic [4:0]  exp_eff;       // clamped prescaler exponent
  logic [20:0] exp_mask;      // low bits that must be all ones
  logic        count_tick;    // countdown clock enable
  logic [8:0]  slot_target;   // nine-bit slot interval
  logic [6:0]  free_space;    // free fifo entries
  logic [1:0]  irq_events;    // events setting sticky status
  logic        start_ok;      // start request with nonzero reload
  logic        slot_unit_end; // one slot interval unit elapsed

  // carrier enable from a fractional accumulator: no second clock,
  // jitter of one system cycle is the price
  always_comb
  begin
    acc_sum      = {1'b0, s.carrier_acc} + {1'b0, CAR_K};
    carrier_tick = (acc_sum >= {1'b0, CLK_K});
  end

  // prescaler: tick whenever the low exponent bits wrap
  always_comb
  begin
    exp_eff = (s.countdown_divider_exponent > `RSM_EXP_MAX)
            ? `RSM_EXP_MAX
            : s.countdown_divider_exponent;
    exp_mask   = (21'h00_0001 << exp_eff) - 21'h00_0001;
    count_tick = carrier_tick
              && ((s.prescale_cnt & exp_mask) == exp_mask);
  end

  // misc helpers
  always_comb
  begin
    slot_target = {s.slot_interval_top_bit, s.slot_interval};
    free_space  = `RSM_FIFO_DEPTH - fifo_count;
    start_ok    = count_start && (s.countdown_reload_value != 8'h00);
    slot_unit_end = carrier_tick && (s.slot_unit_cnt == SLOT_UNIT_LAST);
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  // one process holds every register update so priorities stay in
  // one place: bus writes, then engines, then sticky flags
  always_comb
  begin
    next_s     = s;
    irq_events = 2'b00;

    // register writes; reserved bits are not stored and read as zero,
    // so a host that breaks the fixed values changes nothing
    if (bus.wr)
    begin
      case (bus.addr)
        `RSM_OFS_SLOT_INTERVAL:
          next_s.slot_interval = bus.wdata;
        `RSM_OFS_AUX_SELECT:
        begin
          next_s.slot_interval_top_bit =
            bus.wdata[`RSM_AUX_SLOT_TOP_BIT];
          next_s.aux_output_source =
            bus.wdata[`RSM_AUX_SEL_MSB:`RSM_AUX_SEL_LSB];
        end
        `RSM_OFS_PRESET_27:
          next_s.preset_slot_twenty_seven = bus.wdata;
        `RSM_OFS_FIFO_WARN:
          next_s.fifo_warn_threshold =
            bus.wdata[`RSM_WARN_MSB:`RSM_WARN_LSB];
        `RSM_OFS_COUNTDOWN_CFG:
        begin
          next_s.countdown_auto_reload =
            bus.wdata[`RSM_CFG_AUTO_BIT];
          next_s.countdown_divider_exponent =
            bus.wdata[`RSM_CFG_EXP_MSB:`RSM_CFG_EXP_LSB];
        end
        `RSM_OFS_IRQ_MASK:
          next_s.irq_mask = bus.wdata[1:0];
        `RSM_OFS_RELOAD:
          next_s.countdown_reload_value = bus.wdata;
        default:
          next_s.irq_mask = next_s.irq_mask; // unmapped: ignored
      endcase
    end

    // read data, valid the cycle after the read strobe only
    next_s.rd_data = 8'h00;
    if (bus.rd)
    begin
      case (bus.addr)
        `RSM_OFS_SLOT_INTERVAL:
          next_s.rd_data = s.slot_interval;
        `RSM_OFS_AUX_SELECT:
          next_s.rd_data = {3'b000, s.slot_interval_top_bit, 1'b0,
                            s.aux_output_source};
        `RSM_OFS_FIFO_WARN:
          next_s.rd_data = {2'b00, s.fifo_warn_threshold};
        `RSM_OFS_COUNTDOWN_CFG:
          next_s.rd_data = {2'b00, s.countdown_auto_reload,
                            s.countdown_divider_exponent};
        `RSM_OFS_IRQ_STATUS:
          next_s.rd_data = {6'h00, s.irq_status};
        `RSM_OFS_IRQ_MASK:
          next_s.rd_data = {6'h00, s.irq_mask};
        `RSM_OFS_RELOAD:
          next_s.rd_data = s.countdown_reload_value;
        `RSM_OFS_CONTROL:
          next_s.rd_data = {7'h00, s.count_run};
        `RSM_OFS_COUNT_VALUE:
          next_s.rd_data = s.count_value;
        default:
          next_s.rd_data = 8'h00; // write-only preset and holes
      endcase
    end

    // carrier accumulator and free-running prescale counter
    next_s.carrier_acc = carrier_tick
      ? 17'(acc_sum - {1'b0, CLK_K}) : acc_sum[16:0];
    if (carrier_tick)
      next_s.prescale_cnt = s.prescale_cnt + 21'h00_0001;

    // countdown engine; a software start/stop via the control
    // register behaves like the pins
    if ((count_stop
        || (bus.wr && bus.addr == `RSM_OFS_CONTROL
            && bus.wdata[`RSM_CTRL_STOP_BIT])))
      next_s.count_run = 1'b0;
    else if ((start_ok
        || (bus.wr && bus.addr == `RSM_OFS_CONTROL
            && bus.wdata[`RSM_CTRL_START_BIT]))
        && s.countdown_reload_value != 8'h00)
    begin
      next_s.count_value = s.countdown_reload_value;
      next_s.count_run   = 1'b1;
      next_s.prescale_cnt = 21'h00_0000; // whole first tick period
    end
    else if (s.count_run && count_tick)
    begin
      if (s.count_value > 8'h01)
        next_s.count_value = s.count_value - 8'h01;
      else if (s.countdown_auto_reload)
        next_s.count_value = s.countdown_reload_value;
      else
      begin
        next_s.count_value = 8'h00;
        next_s.count_run   = 1'b0;
        irq_events[`RSM_IRQ_EXPIRED_BIT] = 1'b1;
      end
    end

    // slot interval sequencer; an interval of zero sends nothing
    next_s.auto_send = 1'b0;
    if (carrier_tick)
      next_s.slot_unit_cnt = s.slot_unit_cnt + 7'h01;
    if (frame.tx_begin)
      next_s.slot_from_begin = frame.quit_frame;
    case (s.slot_state)
      rsm_pkg::RSM_SLOT_IDLE:
      begin
        // quit frames count from the frame start, others from its end
        if ((frame.tx_begin && frame.quit_frame)
            || (frame.tx_end && !s.slot_from_begin))
        begin
          if (slot_target != 9'h000)
          begin
            next_s.slot_state    = rsm_pkg::RSM_SLOT_WAIT;
            next_s.slot_cnt      = 9'h000;
            next_s.slot_unit_cnt = 7'h00;
          end
        end
      end
      rsm_pkg::RSM_SLOT_WAIT:
      begin
        if (slot_unit_end)
        begin
          if (s.slot_cnt + 9'h001 >= slot_target)
          begin
            next_s.auto_send  = 1'b1;
            next_s.slot_state = rsm_pkg::RSM_SLOT_IDLE;
            next_s.slot_from_begin = 1'b0;
            irq_events[`RSM_IRQ_SLOT_BIT] = 1'b1;
          end
          else
            next_s.slot_cnt = s.slot_cnt + 9'h001;
        end
      end
      default:
        next_s.slot_state = rsm_pkg::RSM_SLOT_IDLE;
    endcase

    // aux pin mux; demodulator sources are meaningful only for
    // type a at 106 kbd, so they are held low otherwise
    case (s.aux_output_source)
      3'b000: next_s.aux_output_pin = 1'b0;
      3'b001: next_s.aux_output_pin = 1'b1;
      3'b010: next_s.aux_output_pin = aux_src.miller_env;
      3'b011: next_s.aux_output_pin = aux_src.serial_data;
      3'b100: next_s.aux_output_pin =
                aux_src.carrier_demod && aux_src.type_a_106;
      3'b101: next_s.aux_output_pin =
                aux_src.subcarr_demod && aux_src.type_a_106;
      default: next_s.aux_output_pin = 1'b0;
    endcase

    // fifo warning flags against the shared threshold
    next_s.fifo_nearly_full_flag =
      (free_space <= {1'b0, s.fifo_warn_threshold});
    next_s.fifo_nearly_empty_flag =
      (fifo_count <= {1'b0, s.fifo_warn_threshold});

    // sticky status: a status read clears, a new event wins
    if (bus.rd && bus.addr == `RSM_OFS_IRQ_STATUS)
      next_s.irq_status = 2'b00;
    next_s.irq_status = next_s.irq_status | irq_events;
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  // the preset register has no defined reset value, so it alone
  // keeps loading through reset
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      s <= RST_S;
      s.preset_slot_twenty_seven <= next_s.preset_slot_twenty_seven;
    end
    else
      s <= next_s;
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign rd_data                = s.rd_data;
  assign aux_output_pin         = s.aux_output_pin;
  assign fifo_nearly_full_flag  = s.fifo_nearly_full_flag;
  assign fifo_nearly_empty_flag = s.fifo_nearly_empty_flag;
  assign countdown_expired_flag = s.irq_status[`RSM_IRQ_EXPIRED_BIT];
  assign auto_send              = s.auto_send;
  assign preset_value           = s.preset_slot_twenty_seven;
  assign irq                    = |(s.irq_status & s.irq_mask);

endmodule

`default_nettype wire

// File: tb/rsm_host.sv
// host model: drives the plain register port of the config bank
// assumes: shares the bank clock; read data stand one cycle later
`timescale 1ns/1ps
`default_nettype none

module rsm_host
(
  input  wire logic             clock,
  output var rsm_pkg::rsm_bus_s bus,
  input  wire logic [7:0]       rd_data
);
  // ****************************************************************
  // bus idles from time zero, strobes low
  // ****************************************************************
  initial bus = '0;

  // reserved bits of 26h, 29h and 2Ah go out as zero; other addresses are sent unmasked
  function automatic logic [7:0] keep(input logic [7:0] a);
    case (a)
      8'h26:   keep = 8'h17;
      8'h29:   keep = 8'h3F;
      8'h2A:   keep = 8'h3F;
      default: keep = 8'hFF;
    endcase
  endfunction

  // one-cycle write strobe, launched just after an edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    bus <= '{addr: a, wdata: d & keep(a), wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus <= '0;
  endtask

  // read data taken once the answer cycle has settled
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus <= '0;
    #1;
    d = rd_data;
  endtask
endmodule

`default_nettype wire

// File: tb/rsm_cfg_checker.sv
// checker: watches only the ports of the config bank
// assumes: one clock, synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none

module rsm_cfg_checker
(
  input wire logic                  clock,
  input wire logic                  rst,
  input wire rsm_pkg::rsm_bus_s     bus,
  input wire logic [7:0]            rd_data,
  input wire rsm_pkg::rsm_aux_src_s aux_src,
  input wire logic [6:0]            fifo_count,
  input wire logic                  aux_output_pin,
  input wire logic                  fifo_nearly_full_flag,
  input wire logic                  fifo_nearly_empty_flag,
  input wire logic                  countdown_expired_flag,
  input wire logic                  auto_send,
  input wire logic [7:0]            preset_value
);
  // ****************************************************************
  // shadow of the fields the mux, flags and aux readback depend on
  // ****************************************************************
  logic [2:0] sel;  // aux source code
  logic       top;  // slot interval top bit
  logic [5:0] warn; // fifo warning threshold

  // shadow follows host writes, so the mux is judged without the body
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      sel  <= 3'h0;
      top  <= 1'b0;
      warn <= 6'h08;
    end
    else if (bus.wr && bus.addr == 8'h26)
    begin
      sel <= bus.wdata[2:0];
      top <= bus.wdata[4];
    end
    else if (bus.wr && bus.addr == 8'h29)
      warn <= bus.wdata[5:0];
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_low;
    ($past(sel) == 3'h0 || $past(sel) > 3'h5) |-> !aux_output_pin;
  endproperty
  property p_high;
    !$past(rst) && $past(sel) == 3'h1 |-> aux_output_pin;
  endproperty
  property p_miller;
    !$past(rst) && $past(sel) == 3'h2
      |-> aux_output_pin == $past(aux_src.miller_env);
  endproperty
  property p_serial;
    !$past(rst) && $past(sel) == 3'h3
      |-> aux_output_pin == $past(aux_src.serial_data);
  endproperty
  property p_demod;
    !$past(rst) && $past(sel[2:1]) == 2'b10 |-> aux_output_pin ==
      ($past(aux_src.type_a_106) && ($past(sel[0]) ?
       $past(aux_src.subcarr_demod) : $past(aux_src.carrier_demod)));
  endproperty
  property p_full;
    !$past(rst) |-> fifo_nearly_full_flag ==
      ((7'd64 - $past(fifo_count)) <= {1'b0, $past(warn)});
  endproperty
  property p_empty;
    !$past(rst) |->
      fifo_nearly_empty_flag == ($past(fifo_count) <= {1'b0, $past(warn)});
  endproperty
  property p_readback;
    $past(bus.rd && bus.addr == 8'h26)
      |-> rd_data == {3'b000, $past(top), 1'b0, $past(sel)};
  endproperty
  property p_preset;
    $past(bus.wr && bus.addr == 8'h27) |-> preset_value == $past(bus.wdata);
  endproperty
  property p_send_pulse;
    auto_send |=> !auto_send;
  endproperty
  // the expired flag is sticky: it only drops after a status read
  property p_sticky;
    $fell(countdown_expired_flag) |-> $past(bus.rd && bus.addr == 8'h40);
  endproperty

  a_low: assert property (p_low) else $error("aux pin not low");
  a_high: assert property (p_high) else $error("aux pin not high");
  a_miller: assert property (p_miller) else $error("envelope");
  a_serial: assert property (p_serial) else $error("serial");
  a_demod: assert property (p_demod) else $error("demod");
  a_full: assert property (p_full) else $error("nearly full");
  a_empty: assert property (p_empty) else $error("nearly empty");
  a_readback: assert property (p_readback) else $error("aux rb");
  a_preset: assert property (p_preset) else $error("preset");
  a_send_pulse: assert property (p_send_pulse) else $error("send");
  a_sticky: assert property (p_sticky) else $error("sticky");

  c_env: cover property (sel == 3'h2 && aux_output_pin);
  c_send: cover property (auto_send);
  c_exp: cover property ($rose(countdown_expired_flag));
endmodule

bind rsm_cfg rsm_cfg_checker u_chk
(
  .clock(clock), .rst(rst), .bus(bus), .rd_data(rd_data),
  .aux_src(aux_src), .fifo_count(fifo_count),
  .aux_output_pin(aux_output_pin),
  .fifo_nearly_full_flag(fifo_nearly_full_flag),
  .fifo_nearly_empty_flag(fifo_nearly_empty_flag),
  .countdown_expired_flag(countdown_expired_flag),
  .auto_send(auto_send), .preset_value(preset_value)
);

`default_nettype wire

// File: tb/testbench.sv
// testbench: host model on the register port; bench drives frames,
// aux sources, fifo fill and countdown start/stop
// assumes: rsm_cfg with its checker bound in
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic                  clock;
  logic                  rst;
  rsm_pkg::rsm_bus_s     bus;
  logic [7:0]            rd_data, preset, d;
  rsm_pkg::rsm_frame_s   frame;
  rsm_pkg::rsm_aux_src_s aux_src;
  logic [6:0]            fifo_count;
  logic                  count_start, count_stop;
  logic                  pin, full, empty, expired, send, irq;
  int                    bad_count, n_checks;

  rsm_host u_rsm_host (.clock(clock), .bus(bus), .rd_data(rd_data));
  rsm_cfg u_rsm_cfg
  (
    .clock(clock), .rst(rst), .bus(bus), .rd_data(rd_data),
    .frame(frame), .aux_src(aux_src), .fifo_count(fifo_count),
    .count_start(count_start), .count_stop(count_stop),
    .aux_output_pin(pin), .fifo_nearly_full_flag(full),
    .fifo_nearly_empty_flag(empty), .countdown_expired_flag(expired),
    .auto_send(send), .preset_value(preset), .irq(irq)
  );

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] want);
    n_checks++;
    if (seen !== want)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
    end
  endtask

  task automatic rchk(input string what, input logic [7:0] a,
                      input logic [7:0] want);
    u_rsm_host.rd(a, d);
    check(what, d, want);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    rchk("slot", 8'h25, 8'h00);
    rchk("aux", 8'h26, 8'h00);
    rchk("warn", 8'h29, 8'h08);
    rchk("clkcfg", 8'h2A, 8'h07);
    rchk("preset", 8'h27, 8'h00);
    u_rsm_host.wr(8'h27, 8'hA5);
    rchk("unmapped", 8'h30, 8'h00);
    check("preset out", preset, 8'hA5);
    $display("test reset done");
  endtask

  // every source code, with and without the type a 106 qualifier
  task automatic t_aux();
    logic ml, ta, cr, sc, want;
    for (int p = 0; p < 3; p++)
      for (int c = 0; c < 8; c++)
      begin
        ml = p[0];
        ta = (p != 0);
        cr = (p != 2);
        sc = (p != 1);
        @(posedge clock);
        aux_src <= '{ml, !ml, cr, sc, ta};
        u_rsm_host.wr(8'h26, {3'b000, ml, 1'b0, c[2:0]});
        repeat (2) @(posedge clock);
        #1;
        case (c)
          1: want = 1'b1;
          2: want = ml;
          3: want = !ml;
          4: want = ta & cr;
          5: want = ta & sc;
          default: want = 1'b0;
        endcase
        check("aux pin", pin, want);
        rchk("aux rb", 8'h26, {3'b000, ml, 1'b0, c[2:0]});
      end
    $display("test aux done");
  endtask

  task automatic t_fifo();
    int wl [3] = '{0, 16, 63};
    int cn [8] = '{0, 1, 16, 17, 47, 48, 63, 64};
    foreach (wl[i])
    begin
      u_rsm_host.wr(8'h29, wl[i][7:0]);
      foreach (cn[j])
      begin
        @(posedge clock);
        fifo_count <= cn[j][6:0];
        repeat (2) @(posedge clock);
        #1;
        check("full", full, 16'(64 - cn[j] <= wl[i]));
        check("empty", empty, 16'(cn[j] <= wl[i]));
      end
    end
    $display("test fifo done");
  endtask

  // one-shot countdown at two divider settings, then mask and clear
  task automatic t_timer();
    int n, mid;
    u_rsm_host.wr(8'h42, 8'h03);
    for (int e = 0; e < 3; e += 2)
    begin
      u_rsm_host.wr(8'h41, 8'h01);
      u_rsm_host.wr(8'h2A, e[7:0]);
      @(posedge clock);
      count_start <= 1'b1;
      @(posedge clock);
      count_start <= 1'b0;
      n = 0;
      while (expired !== 1'b1 && n < 200)
      begin
        @(posedge clock);
        #1;
        n++;
      end
      mid = (3 << e) * 7375 / 1000;
      check("expiry time", n >= mid - 10 && n <= mid + 10, 1);
      check("irq on", irq, 1'b1);
      u_rsm_host.wr(8'h41, 8'h00);
      #1;
      check("irq masked", irq, 1'b0);
      rchk("count", 8'h44, 8'h00);
      rchk("halted", 8'h43, 8'h00);
      rchk("status", 8'h40, 8'h01);
      check("cleared", expired, 1'b0);
    end
    $display("test timer done");
  endtask

  task automatic t_reload();
    u_rsm_host.wr(8'h42, 8'h00);
    u_rsm_host.wr(8'h43, 8'h01);
    rchk("zero load", 8'h43, 8'h00);
    u_rsm_host.wr(8'h42, 8'h02);
    u_rsm_host.wr(8'h2A, 8'h20);
    u_rsm_host.wr(8'h43, 8'h01);
    repeat (150) @(posedge clock);
    #1;
    check("no expiry", expired, 1'b0);
    rchk("reloading", 8'h43, 8'h01);
    u_rsm_host.wr(8'h2A, 8'h1F);
    u_rsm_host.wr(8'h42, 8'h01);
    u_rsm_host.wr(8'h43, 8'h01);
    repeat (100) @(posedge clock);
    rchk("clamped", 8'h43, 8'h01);
    @(posedge clock);
    count_stop <= 1'b1;
    @(posedge clock);
    count_stop <= 1'b0;
    rchk("stopped", 8'h43, 8'h00);
    $display("test reload done");
  endtask

  // interval of two units, timed from tx_begin; quit frames count
  // from the frame start, others from the end 1000 cycles later
  task automatic t_slot();
    int n, lo;
    u_rsm_host.wr(8'h41, 8'h02);
    u_rsm_host.wr(8'h25, 8'h02);
    for (int q = 0; q < 2; q++)
    begin
      @(posedge clock);
      frame <= '{1'b1, 1'b0, q[0]};
      n = 0;
      while (send !== 1'b1 && n < 4000)
      begin
        @(posedge clock);
        frame <= '{1'b0, n == 999, 1'b0};
        #1;
        n++;
      end
      lo = q ? 1870 : 2870;
      check("slot time", n >= lo && n <= lo + 40, 1);
      check("slot irq", irq, 1'b1);
      rchk("slot status", 8'h40, 8'h02);
    end
    $display("test slot done");
  endtask

  initial
  begin
    repeat (50000) @(posedge clock);
    bad_count++;
    close_out();
  end

  initial
  begin
    rst = 1'b1;
    frame = '0;
    aux_src = '0;
    fifo_count = 7'h00;
    count_start = 1'b0;
    count_stop = 1'b0;
    bad_count = 0;
    n_checks = 0;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_aux();
    t_fifo();
    t_timer();
    t_reload();
    t_slot();
    close_out();
  end
endmodule

`default_nettype wire
